//--- rtl/exec_pkg.sv
package exec_pkg;

    typedef enum logic [3:0] {
        rotate_left_carry_op,
        rotate_right_carry_op,
        literal_minus_acc_op,
        reg_minus_acc_op,
        reg_minus_acc_borrow_op,
        nibble_exchange_op,
        literal_xor_op,
        register_xor_op,
        pin_direction_load_op,
        sleep_op
    } op_t;

    // Operand carries the literal, the register value or the port select
    typedef struct packed {
        op_t op;
        logic dest;
        logic [6:0] addr;
        logic [7:0] opnd;
    } op_req_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_t;

    typedef struct packed {
        logic watchdog_expiry_flag;
        logic powerdown_flag;
        logic z;
        logic half_carry_flag;
        logic c;
    } flags_t;

    // Register word indexes
    localparam logic [2:0] ACC_OFS = 3'h0;
    localparam logic [2:0] STATUS_OFS = 3'h1;
    localparam logic [2:0] DIR_A_OFS = 3'h2;
    localparam logic [2:0] DIR_B_OFS = 3'h3;
    localparam logic [2:0] DIR_C_OFS = 3'h4;
    localparam logic [2:0] WATCHDOG_OFS = 3'h5;
    localparam logic [2:0] STATE_OFS = 3'h6;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam flags_t FLAGS_RST = 5'h18;
    localparam logic [7:0] WATCHDOG_CLR = 8'h00;

    // Direction load selects and destination code
    localparam logic [2:0] SEL_A = 3'h5;
    localparam logic [2:0] SEL_B = 3'h6;
    localparam logic [2:0] SEL_C = 3'h7;
    localparam logic DEST_ACC = 1'b0;

    function automatic logic is_reg_op(input op_t op);
        return op inside {rotate_left_carry_op, rotate_right_carry_op,
                          reg_minus_acc_op, reg_minus_acc_borrow_op,
                          nibble_exchange_op, register_xor_op};
    endfunction

endpackage

//--- rtl/exec_alu.sv
module exec_alu (
    // Operation
    input exec_pkg::op_req_t req_in,
    input logic [7:0] acc_in,
    input exec_pkg::flags_t flags_in,
    // Result
    output logic [7:0] result_out,
    output exec_pkg::flags_t flags_out,
    output logic to_acc_out,
    output logic to_file_out,
    output logic [2:0] dir_we_out
);
    logic cin;
    logic [8:0] diff;
    logic [4:0] half;
    logic [7:0] x;

    always_comb begin
        x = req_in.opnd;
        cin = (req_in.op == exec_pkg::reg_minus_acc_borrow_op) ?
              flags_in.c : 1'b1;
        diff = {1'b0, x} + {1'b0, ~acc_in} + {8'h00, cin};
        half = {1'b0, x[3:0]} + {1'b0, ~acc_in[3:0]} + {4'h0, cin};
        flags_out = flags_in;
        result_out = x;
        dir_we_out = 3'h0;
        to_file_out = exec_pkg::is_reg_op(req_in.op) &&
                      req_in.dest != exec_pkg::DEST_ACC;
        to_acc_out = (exec_pkg::is_reg_op(req_in.op) &&
                      req_in.dest == exec_pkg::DEST_ACC) ||
                     req_in.op == exec_pkg::literal_minus_acc_op ||
                     req_in.op == exec_pkg::literal_xor_op;
        case (req_in.op)
            exec_pkg::rotate_left_carry_op: begin
                result_out = {x[6:0], flags_in.c};
                flags_out.c = x[7];
            end
            exec_pkg::rotate_right_carry_op: begin
                result_out = {flags_in.c, x[7:1]};
                flags_out.c = x[0];
            end
            exec_pkg::literal_minus_acc_op,
            exec_pkg::reg_minus_acc_op,
            exec_pkg::reg_minus_acc_borrow_op: begin
                result_out = diff[7:0];
                flags_out.c = diff[8];
                flags_out.half_carry_flag = half[4];
                flags_out.z = (diff[7:0] == 8'h00);
            end
            exec_pkg::nibble_exchange_op: begin
                result_out = {x[3:0], x[7:4]};
            end
            exec_pkg::literal_xor_op,
            exec_pkg::register_xor_op: begin
                result_out = x ^ acc_in;
                flags_out.z = ((x ^ acc_in) == 8'h00);
            end
            exec_pkg::pin_direction_load_op: begin
                result_out = acc_in;
                // Whole operand compared: aliases of 5..7 load nothing
                dir_we_out[0] = (x == {5'h00, exec_pkg::SEL_A});
                dir_we_out[1] = (x == {5'h00, exec_pkg::SEL_B});
                dir_we_out[2] = (x == {5'h00, exec_pkg::SEL_C});
            end
            default: begin
                result_out = x;
            end
        endcase
    end

endmodule // exec_alu

//--- rtl/exec_unit.sv
// The address map and the Avalon-MM register port were chosen for this implementation.
module exec_unit (
    // Clock and reset
    input logic mclk_in,
    input logic rst_in,
    // Decoder side
    input logic op_valid_in,
    input exec_pkg::op_req_t op_req_in,
    output logic op_ready_out,
    // Register file write
    output exec_pkg::file_wr_t file_wr_out,
    // Port direction and power
    output logic [7:0] port_a_direction_out,
    output logic [7:0] port_b_direction_out,
    output logic [7:0] port_c_direction_out,
    output logic sleep_out,
    output logic osc_halt_out,
    input logic wake_in,
    // Avalon-MM slave
    input logic [2:0] avs_address_in,
    input logic avs_read_in,
    input logic avs_write_in,
    input logic [31:0] avs_writedata_in,
    input logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    logic [7:0] acc_ff;
    exec_pkg::flags_t flags_ff;
    logic [7:0] dir_a_ff;
    logic [7:0] dir_b_ff;
    logic [7:0] dir_c_ff;
    logic [7:0] presc_ff;
    logic [7:0] watchdog_counter_ff;
    logic sleep_ff;
    exec_pkg::file_wr_t file_wr_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;

    logic bus_req;
    logic op_fire;
    logic bus_wr;
    logic is_sleep;
    logic [7:0] nxt_rdata;
    logic [7:0] alu_result;
    exec_pkg::flags_t alu_flags;
    logic alu_to_acc;
    logic alu_to_file;
    logic [2:0] alu_dir_we;
    logic [7:0] wdata;

    exec_alu u_alu (
        .req_in(op_req_in),
        .acc_in(acc_ff),
        .flags_in(flags_ff),
        .result_out(alu_result),
        .flags_out(alu_flags),
        .to_acc_out(alu_to_acc),
        .to_file_out(alu_to_file),
        .dir_we_out(alu_dir_we)
    );

    // Bus and decoder never act in the same cycle, so no write race
    assign bus_req = avs_read_in | avs_write_in;
    assign op_ready_out = ~sleep_ff & ~(bus_req & ack_ff);
    assign op_fire = op_valid_in & op_ready_out;
    assign bus_wr = avs_write_in & ack_ff & avs_byteenable_in[0];
    assign wdata = avs_writedata_in[7:0];
    assign is_sleep = op_fire && op_req_in.op == exec_pkg::sleep_op;
    assign avs_waitrequest_out = bus_req & ~ack_ff;
    assign avs_readdata_out = rdata_ff;
    assign file_wr_out = file_wr_ff;
    assign port_a_direction_out = dir_a_ff;
    assign port_b_direction_out = dir_b_ff;
    assign port_c_direction_out = dir_c_ff;
    assign sleep_out = sleep_ff;
    assign osc_halt_out = sleep_ff;

    // Accumulator
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            acc_ff <= exec_pkg::ACC_RST;
        end else if (op_fire && alu_to_acc) begin
            acc_ff <= alu_result;
        end else if (bus_wr && avs_address_in == exec_pkg::ACC_OFS) begin
            acc_ff <= wdata;
        end
    end

    // Status flags
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            flags_ff <= exec_pkg::FLAGS_RST;
        end else if (is_sleep) begin
            flags_ff.watchdog_expiry_flag <= 1'b1;
            flags_ff.powerdown_flag <= 1'b0;
        end else if (op_fire) begin
            flags_ff <= alu_flags;
        end else if (bus_wr &&
                     avs_address_in == exec_pkg::STATUS_OFS) begin
            flags_ff <= wdata[4:0];
        end
    end

    // Port direction registers
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            dir_a_ff <= exec_pkg::DIR_RST;
            dir_b_ff <= exec_pkg::DIR_RST;
            dir_c_ff <= exec_pkg::DIR_RST;
        end else if (op_fire) begin
            if (alu_dir_we[0]) begin
                dir_a_ff <= alu_result;
            end
            if (alu_dir_we[1]) begin
                dir_b_ff <= alu_result;
            end
            if (alu_dir_we[2]) begin
                dir_c_ff <= alu_result;
            end
        end else if (bus_wr) begin
            if (avs_address_in == exec_pkg::DIR_A_OFS) begin
                dir_a_ff <= wdata;
            end
            if (avs_address_in == exec_pkg::DIR_B_OFS) begin
                dir_b_ff <= wdata;
            end
            if (avs_address_in == exec_pkg::DIR_C_OFS) begin
                dir_c_ff <= wdata;
            end
        end
    end

    // Watchdog keeps counting in sleep: it is clocked by mclk_in like the rest of the block
    always_ff @(posedge mclk_in) begin
        if (rst_in || is_sleep) begin
            presc_ff <= exec_pkg::WATCHDOG_CLR;
            watchdog_counter_ff <= exec_pkg::WATCHDOG_CLR;
        end else begin
            presc_ff <= presc_ff + 8'h01;
            if (presc_ff == 8'hff) begin
                watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
            end
        end
    end

    // Sleep state
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sleep_ff <= 1'b0;
        end else if (is_sleep) begin
            sleep_ff <= 1'b1;
        end else if (wake_in) begin
            sleep_ff <= 1'b0;
        end
    end

    // Register file write, one cycle after the operation
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            file_wr_ff <= '0;
        end else begin
            file_wr_ff.we <= op_fire & alu_to_file;
            file_wr_ff.addr <= op_req_in.addr;
            file_wr_ff.data <= alu_result;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        case (avs_address_in)
            exec_pkg::ACC_OFS: nxt_rdata = acc_ff;
            exec_pkg::STATUS_OFS: nxt_rdata = {3'h0, flags_ff};
            exec_pkg::DIR_A_OFS: nxt_rdata = dir_a_ff;
            exec_pkg::DIR_B_OFS: nxt_rdata = dir_b_ff;
            exec_pkg::DIR_C_OFS: nxt_rdata = dir_c_ff;
            exec_pkg::WATCHDOG_OFS: nxt_rdata = watchdog_counter_ff;
            exec_pkg::STATE_OFS: nxt_rdata = {7'h00, sleep_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Bus answer one cycle after request unless an op takes the cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff <= bus_req & ~ack_ff & ~op_fire;
            if (avs_read_in && !ack_ff && !op_fire) begin
                rdata_ff <= {24'h000000, nxt_rdata};
            end
        end
    end

    // Helper state for checks
    logic last_fire_ff;
    exec_pkg::op_req_t last_req_ff;
    logic [7:0] last_acc_ff;
    exec_pkg::flags_t last_flags_ff;
    logic [7:0] k;
    logic [7:0] w;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            last_fire_ff <= 1'b0;
            last_req_ff <= '0;
            last_acc_ff <= 8'h00;
            last_flags_ff <= '0;
        end else begin
            last_fire_ff <= op_fire;
            last_req_ff <= op_req_in;
            last_acc_ff <= acc_ff;
            last_flags_ff <= flags_ff;
        end
    end

    assign k = last_req_ff.opnd;
    assign w = last_acc_ff;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    rot_left_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::rotate_left_carry_op &&
        last_req_ff.dest == 1'b0
        |-> acc_ff == {k[6:0], last_flags_ff.c} && flags_ff.c == k[7])
        else $error("rotate left wrong");

    rot_right_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::rotate_right_carry_op
        |-> file_wr_ff.data == {last_flags_ff.c, k[7:1]} &&
            flags_ff.c == k[0] &&
            flags_ff[4:1] == last_flags_ff[4:1])
        else $error("rotate right wrong");

    dest_file_a: assert property (
        last_fire_ff && exec_pkg::is_reg_op(last_req_ff.op)
        |-> file_wr_ff.we == last_req_ff.dest &&
            (last_req_ff.dest ? acc_ff == w : 1'b1))
        else $error("destination routing wrong");

    lit_sub_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::literal_minus_acc_op
        |-> acc_ff == k - w && flags_ff.c == (w <= k) &&
            flags_ff.half_carry_flag == (w[3:0] <= k[3:0]))
        else $error("literal subtract wrong");

    reg_sub_a: assert property (
        op_fire && op_req_in.op == exec_pkg::reg_minus_acc_op &&
        op_req_in.dest == 1'b1
        |=> file_wr_ff.we && file_wr_ff.data == k - w &&
            flags_ff.c == (w <= k) &&
            flags_ff.z == (k == w))
        else $error("register subtract wrong");

    borrow_sub_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::reg_minus_acc_borrow_op
        |-> file_wr_ff.data ==
            8'(k - w - {7'h00, ~last_flags_ff.c}))
        else $error("borrow subtract wrong");

    sleep_status_a: assert property (
        is_sleep
        |=> watchdog_counter_ff == 8'h00 && presc_ff == 8'h00 &&
            flags_ff.watchdog_expiry_flag && !flags_ff.powerdown_flag
        ##1 presc_ff == 8'h01)
        else $error("sleep status wrong");

    sleep_halt_a: assert property (
        is_sleep |=> osc_halt_out && !op_ready_out)
        else $error("sleep did not halt");

    swap_keep_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::nibble_exchange_op
        |-> file_wr_ff.data == {k[3:0], k[7:4]} &&
            flags_ff == last_flags_ff)
        else $error("swap wrong");

    lit_xor_a: assert property (
        last_fire_ff && last_req_ff.op == exec_pkg::literal_xor_op
        |-> acc_ff == (k ^ w) && !file_wr_ff.we &&
            flags_ff.c == last_flags_ff.c &&
            flags_ff.half_carry_flag == last_flags_ff.half_carry_flag)
        else $error("literal xor wrong");

    reg_xor_a: assert property (
        last_fire_ff && last_req_ff.op == exec_pkg::register_xor_op
        |-> file_wr_ff.data == (k ^ w) &&
            flags_ff.c == last_flags_ff.c &&
            flags_ff.half_carry_flag == last_flags_ff.half_carry_flag)
        else $error("register xor wrong");

    dir_load_a: assert property (
        last_fire_ff &&
        last_req_ff.op == exec_pkg::pin_direction_load_op &&
        k == {5'h00, exec_pkg::SEL_B}
        |-> dir_b_ff == w && flags_ff == last_flags_ff &&
            dir_a_ff == $past(dir_a_ff))
        else $error("direction load wrong");

    zero_flag_a: assert property (
        last_fire_ff &&
        (last_req_ff.op == exec_pkg::literal_xor_op ||
         last_req_ff.op == exec_pkg::literal_minus_acc_op)
        |-> flags_ff.z == (acc_ff == 8'h00))
        else $error("zero flag wrong");

    bus_answer_a: assert property (
        bus_req && !ack_ff && !op_fire |=> !avs_waitrequest_out)
        else $error("bus answer late");

endmodule // exec_unit

//--- bench/reg_file_model.sv
module reg_file_model (
    // Clock
    input wire logic mclk_in,
    // Write port from the block
    input wire exec_pkg::file_wr_t file_wr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [128];

    // Distinct start values so a wrong address shows
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 29 + 3);
        end
    end

    always @(posedge mclk_in) begin
        if (file_wr_in.we === 1'b1) begin
            mem[file_wr_in.addr] <= file_wr_in.data;
        end
    end
endmodule // reg_file_model

//--- bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, op_valid = 0, rd = 0, wr = 0, wake = 0;
    exec_pkg::op_req_t op_req = '0;
    exec_pkg::file_wr_t file_wr;
    logic [2:0] addr = 3'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] dir_a, dir_b, dir_c, v;
    logic op_ready, sleep, halt, waitreq;
    int fails = 0, n_tests = 0;

    always #4 mclk = ~mclk;

    exec_unit i_exec_unit (.mclk_in(mclk), .rst_in(rst),
        .op_valid_in(op_valid), .op_req_in(op_req),
        .op_ready_out(op_ready), .file_wr_out(file_wr),
        .port_a_direction_out(dir_a), .port_b_direction_out(dir_b),
        .port_c_direction_out(dir_c), .sleep_out(sleep),
        .osc_halt_out(halt), .wake_in(wake), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq));
    reg_file_model i_reg_file_model (.mclk_in(mclk), .file_wr_in(file_wr));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Request stands until waitrequest is sampled low at a rising edge
    task automatic bus(input logic [2:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
        int i;
        @(posedge mclk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, d};
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (waitreq === 1'b0) begin
                break;
            end
        end
        q = rdata[7:0];
        rd <= 0;
        wr <= 0;
        if (i == 20) begin
            fails++;
            stop_test();
        end
    endtask

    // Ends at the falling edge of the cycle after the taking edge
    task automatic send(input exec_pkg::op_req_t q);
        int i;
        @(posedge mclk);
        op_valid <= 1;
        op_req <= q;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (op_ready === 1'b1) begin
                break;
            end
        end
        op_valid <= 0;
        if (i == 20) begin
            fails++;
            stop_test();
        end
        @(negedge mclk);
    endtask

    // Result, then zero, half-carry, carry; untouched flags pass through
    function automatic logic [10:0] model(exec_pkg::op_t op,
        logic [7:0] a, logic [7:0] r, logic [2:0] f);
        logic [8:0] d;
        logic [4:0] h;
        logic b;
        b = (op == exec_pkg::reg_minus_acc_borrow_op) ? ~f[0] : 1'b0;
        d = {1'b0, r} - a - b;
        h = {1'b0, r[3:0]} - a[3:0] - b;
        case (op)
            exec_pkg::rotate_left_carry_op: return {r[6:0], f[0], f[2:1], r[7]};
            exec_pkg::rotate_right_carry_op: return {f[0], r[7:1], f[2:1], r[0]};
            exec_pkg::nibble_exchange_op: return {r[3:0], r[7:4], f};
            exec_pkg::literal_xor_op, exec_pkg::register_xor_op:
                return {a ^ r, (a ^ r) == 8'h00, f[1:0]};
            default: return {d[7:0], d[7:0] == 8'h00, ~h[4], ~d[8]};
        endcase
    endfunction

    task automatic do_op(input exec_pkg::op_t op, input logic dest,
        input logic [6:0] ra, input logic [7:0] lit,
        input logic [7:0] a, input logic [2:0] f);
        logic [7:0] r, q;
        logic [10:0] e;
        logic to_reg;
        to_reg = dest && !(op inside {exec_pkg::literal_minus_acc_op,
                                      exec_pkg::literal_xor_op});
        bus(3'h0, 1, a, q);
        bus(3'h1, 1, {3'h0, 2'b11, f}, q);
        r = (op inside {exec_pkg::literal_minus_acc_op,
                        exec_pkg::literal_xor_op}) ? lit : i_reg_file_model.mem[ra];
        e = model(op, a, r, f);
        send('{op, dest, ra, r});
        check(file_wr.we, to_reg);
        if (to_reg) begin
            check({file_wr.addr, file_wr.data}, {ra, e[10:3]});
        end
        bus(3'h0, 0, 8'h00, q);
        check(q, to_reg ? a : e[10:3]);
        bus(3'h1, 0, 8'h00, q);
        check(q, {3'h0, 2'b11, e[2:0]});
    endtask

    task automatic t_reset();
        bus(3'h1, 0, 8'h00, v);
        check(v, 8'h18);
        bus(3'h0, 0, 8'h00, v);
        check(v, 8'h00);
        bus(3'h7, 0, 8'h00, v);
        check(v, 8'h00);
        check({dir_a, dir_b, dir_c, sleep}, {24'hffffff, 1'b0});
        $display("test reset done");
    endtask

    task automatic t_rotate();
        for (int k = 0; k < 8; k++) begin
            do_op(k[2] ? exec_pkg::rotate_right_carry_op :
                  exec_pkg::rotate_left_carry_op, k[1], 7'(k + 9),
                  8'h00, 8'h3c, {2'b11, k[0]});
        end
        $display("test rotate done");
    endtask

    task automatic t_sub();
        do_op(exec_pkg::literal_minus_acc_op, 0, 0, 8'h05, 8'h05, 3'h0);
        do_op(exec_pkg::literal_minus_acc_op, 1, 0, 8'h05, 8'h06, 3'h7);
        do_op(exec_pkg::literal_minus_acc_op, 0, 0, 8'h21, 8'h18, 3'h0);
        do_op(exec_pkg::reg_minus_acc_op, 0, 22, 0, 8'h81, 3'h0);
        do_op(exec_pkg::reg_minus_acc_op, 0, 21, 0, 8'hff, 3'h4);
        do_op(exec_pkg::reg_minus_acc_borrow_op, 0, 22, 0, 8'h81, 3'h6);
        do_op(exec_pkg::reg_minus_acc_borrow_op, 0, 22, 0, 8'h81, 3'h1);
        do_op(exec_pkg::reg_minus_acc_borrow_op, 1, 23, 0, 8'h0f, 3'h0);
        do_op(exec_pkg::reg_minus_acc_op, 1, 20, 0, 8'h42, 3'h7);
        $display("test subtract done");
    endtask

    task automatic t_swap_xor();
        do_op(exec_pkg::nibble_exchange_op, 0, 30, 0, 8'h00, 3'h7);
        do_op(exec_pkg::nibble_exchange_op, 1, 31, 0, 8'h00, 3'h2);
        do_op(exec_pkg::literal_xor_op, 0, 0, 8'hff, 8'hff, 3'h3);
        do_op(exec_pkg::literal_xor_op, 1, 0, 8'ha5, 8'h0f, 3'h7);
        do_op(exec_pkg::register_xor_op, 1, 40, 0, 8'h5a, 3'h4);
        do_op(exec_pkg::register_xor_op, 0, 41, 0, 8'h33, 3'h0);
        $display("test swap xor done");
    endtask

    // Select 4 must load nothing, so it runs first against reset values
    task automatic t_dir();
        logic [7:0] e [3];
        e = '{8'hff, 8'hff, 8'hff};
        for (int s = 4; s < 8; s++) begin
            bus(3'h1, 1, 8'h1a, v);
            bus(3'h0, 1, 8'(8'h50 + s), v);
            send('{exec_pkg::pin_direction_load_op, 1'b0, 7'h0, 8'(s)});
            if (s > 4) begin
                e[s - 5] = 8'(8'h50 + s);
            end
            check({dir_a, dir_b, dir_c}, {e[0], e[1], e[2]});
            bus(3'h1, 0, 8'h00, v);
            check(v, 8'h1a);
        end
        // Alias of select 6 in the upper bits must load nothing
        send('{exec_pkg::pin_direction_load_op, 1'b0, 7'h0, 8'h0e});
        check({dir_a, dir_b, dir_c}, {e[0], e[1], e[2]});
        $display("test direction done");
    endtask

    task automatic t_sleep();
        bus(3'h1, 1, 8'h0b, v);
        // Long enough for a prescaler wrap, so the clear is visible
        repeat (300) @(posedge mclk);
        bus(3'h5, 0, 8'h00, v);
        check(v != 8'h00, 1'b1);
        send('{exec_pkg::sleep_op, 1'b0, 7'h0, 8'h00});
        check({sleep, halt, op_ready}, 3'b110);
        bus(3'h1, 0, 8'h00, v);
        check(v, 8'h13);
        bus(3'h5, 0, 8'h00, v);
        check(v, 8'h00);
        bus(3'h6, 0, 8'h00, v);
        check(v, 8'h01);
        @(posedge mclk);
        wake <= 1;
        @(posedge mclk);
        wake <= 0;
        @(negedge mclk);
        check({sleep, halt}, 2'b00);
        do_op(exec_pkg::literal_xor_op, 0, 0, 8'h01, 8'h01, 3'h0);
        $display("test sleep done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 0;
        t_reset();
        t_rotate();
        t_sub();
        t_swap_xor();
        t_dir();
        t_sleep();
        stop_test();
    end
endmodule // tb
